//--- rtl/fbref_regs.vh
`ifndef FBREF_REGS_VH
`define FBREF_REGS_VH

// Word addresses of the virtual address map
`define ADDR_COMMAND 3'h1
`define ADDR_PRIMARY 3'h2
`define ADDR_SECONDARY 3'h3
`define ADDR_STATE 3'h4
`define ADDR_SPEED_FB 3'h5
`define ADDR_TORQUE_FB 3'h6

// Reset value of every stored map word; the state word is not stored and has none
`define WORD_RESET 16'h0000

// Full-scale counts: primary 20000, secondary and torque 10000
`define PRIMARY_FULL_SCALE 32'h00004E20
`define SECONDARY_FULL_SCALE 32'h00002710
`define TORQUE_FULL_SCALE 32'h00002710
`define WORD_LIMIT 32'h00007FFF

// Torque input resolution 0.1 %, feedback resolution 0.01 %
`define TORQUE_INPUT_FACTOR 32'h0000000A

// Analog input one in 0.1 % steps, 1000 = 100 %
`define ANALOG_FULL_SCALE 32'h000003E8

// Direction settings
`define DIR_FORWARD 2'h1
`define DIR_REVERSE 2'h2
`define DIR_REQUEST 2'h3

// Analog combination modes
`define COMBINE_NONE 2'h0
`define COMBINE_ADD 2'h1
`define COMBINE_MUL 2'h2

// Secondary reference types
`define SEC_TYPE_SPEED 2'h0
`define SEC_TYPE_TORQUE 2'h1
`define SEC_TYPE_PID 2'h2

// Location flag position in the state word
`define LOC_FLAG_BIT 11

`endif

//--- rtl/signed_limiter.v
`timescale 1ns/1ps
`default_nettype none

module signed_limiter #(
    parameter WIDTH = 16
) (
    input wire signed [WIDTH-1:0] value,
    input wire signed [WIDTH-1:0] low,
    input wire signed [WIDTH-1:0] high,
    output reg signed [WIDTH-1:0] limited
);

always @* begin
    if (value > high)
        limited = high;
    else if (value < low)
        limited = low;
    else
        limited = value;
end

endmodule // signed_limiter

`default_nettype wire

//--- rtl/reference_scaler.v
`timescale 1ns/1ps
`default_nettype none
`include "fbref_regs.vh"

module reference_scaler #(
    parameter FULL_SCALE = 20000
) (
    input wire clk,
    input wire rst,
    input wire signed [15:0] word,
    input wire [9:0] analog,
    input wire [1:0] combine,
    input wire [1:0] direction,
    input wire [15:0] maximum,
    output reg signed [15:0] scaled
);

localparam signed [31:0] FS = FULL_SCALE;
localparam signed [31:0] HALF = FULL_SCALE / 2;

reg signed [31:0] w;
reg signed [31:0] ai_w;
reg signed [31:0] c;
reg signed [31:0] mag;
reg signed [31:0] s;

always @* begin
    w = {{16{word[15]}}, word};
    ai_w = $signed({22'h0, analog}) * FS / $signed(`ANALOG_FULL_SCALE);
    case (combine)
        `COMBINE_ADD: c = w + ai_w - HALF;
        `COMBINE_MUL: c = w * ai_w / HALF;
        default: c = w;
    endcase
    mag = (c < 0) ? -c : c;
    case (direction)
        `DIR_FORWARD: c = mag;
        `DIR_REVERSE: c = -mag;
        default: c = c;
    endcase
    // Beyond full scale the reference sticks at the configured maximum
    if (c > FS)
        c = FS;
    else if (c < -FS)
        c = -FS;
    // Only the maximum sets the slope, the minimum never enters here
    s = c * $signed({16'h0000, maximum}) / FS;
end

always @(posedge clk or posedge rst) begin
    if (rst)
        scaled <= `WORD_RESET;
    else
        scaled <= s[15:0];
end

endmodule // reference_scaler

`default_nettype wire

//--- rtl/fieldbus_reference_scaling.v
`timescale 1ns/1ps
`default_nettype none
`include "fbref_regs.vh"

module fieldbus_reference_scaling (
    input wire CLK,
    input wire RST,
    input wire [2:0] ADDR,
    input wire WR,
    input wire RD,
    input wire [15:0] WDATA,
    output reg [15:0] RDATA,
    output reg [15:0] COMMAND_WORD,
    input wire [15:0] STATE_BITS,
    input wire EXTERNAL_LOCATION_SELECT,
    input wire [1:0] DIRECTION_ONE,
    input wire [1:0] DIRECTION_TWO,
    input wire [9:0] ANALOG_INPUT_ONE,
    input wire [1:0] PRIMARY_COMBINE,
    input wire [1:0] SECONDARY_COMBINE,
    input wire [15:0] PRIMARY_REFERENCE_MAXIMUM,
    input wire [15:0] PRIMARY_REFERENCE_MINIMUM,
    input wire [15:0] SECONDARY_REFERENCE_MAXIMUM,
    input wire [15:0] SECONDARY_REFERENCE_MINIMUM,
    input wire FREQUENCY_MODE,
    input wire signed [15:0] SPEED_LIMIT_MIN,
    input wire signed [15:0] SPEED_LIMIT_MAX,
    input wire signed [15:0] FREQUENCY_LIMIT_MIN,
    input wire signed [15:0] FREQUENCY_LIMIT_MAX,
    input wire [1:0] SECONDARY_TYPE,
    input wire TORQUE_SET_SELECT,
    input wire signed [15:0] TORQUE1_LIMIT_MIN,
    input wire signed [15:0] TORQUE1_LIMIT_MAX,
    input wire signed [15:0] TORQUE2_LIMIT_MIN,
    input wire signed [15:0] TORQUE2_LIMIT_MAX,
    input wire PID_SET_SELECT,
    input wire signed [15:0] PID1_SETPOINT_MIN,
    input wire signed [15:0] PID1_SETPOINT_MAX,
    input wire signed [15:0] PID2_SETPOINT_MIN,
    input wire signed [15:0] PID2_SETPOINT_MAX,
    input wire signed [15:0] ACTUAL_SPEED,
    input wire signed [15:0] ACTUAL_TORQUE,
    output reg signed [15:0] PRIMARY_REFERENCE,
    output reg signed [15:0] PRIMARY_DRIVE_REFERENCE,
    output reg signed [15:0] SECONDARY_REFERENCE
);

////////////////////////////////////////////////////////////////////////////////
// Address map words

reg [15:0] primary_reference_word;
reg [15:0] secondary_reference_word;
reg [15:0] speed_feedback_word;
reg [15:0] torque_feedback_word;
wire [15:0] state_word;

// Location flag overrides whatever the state source has in that bit
assign state_word = {STATE_BITS[15:`LOC_FLAG_BIT+1], EXTERNAL_LOCATION_SELECT,
                     STATE_BITS[`LOC_FLAG_BIT-1:0]};

always @(posedge CLK or posedge RST) begin
    if (RST) begin
        COMMAND_WORD <= `WORD_RESET;
        primary_reference_word <= `WORD_RESET;
        secondary_reference_word <= `WORD_RESET;
    end else if (WR) begin
        // Writes to read-only or unmapped words are dropped
        case (ADDR)
            `ADDR_COMMAND: COMMAND_WORD <= WDATA;
            `ADDR_PRIMARY: primary_reference_word <= WDATA;
            `ADDR_SECONDARY: secondary_reference_word <= WDATA;
            default: ;
        endcase
    end
end

reg [15:0] next_rdata;

always @* begin
    case (ADDR)
        `ADDR_COMMAND: next_rdata = COMMAND_WORD;
        `ADDR_PRIMARY: next_rdata = primary_reference_word;
        `ADDR_SECONDARY: next_rdata = secondary_reference_word;
        `ADDR_STATE: next_rdata = state_word;
        `ADDR_SPEED_FB: next_rdata = speed_feedback_word;
        `ADDR_TORQUE_FB: next_rdata = torque_feedback_word;
        default: next_rdata = 16'h0000;
    endcase
end

// Read data holds its last value between reads
always @(posedge CLK or posedge RST) begin
    if (RST)
        RDATA <= `WORD_RESET;
    else if (RD)
        RDATA <= next_rdata;
end

////////////////////////////////////////////////////////////////////////////////
// Reference scaling

wire [1:0] direction;
wire signed [15:0] primary_scaled;
wire signed [15:0] secondary_scaled;

assign direction = EXTERNAL_LOCATION_SELECT ? DIRECTION_TWO : DIRECTION_ONE;

reference_scaler #(
    .FULL_SCALE(20000)
) primary_scaler (
    .clk(CLK),
    .rst(RST),
    .word(primary_reference_word),
    .analog(ANALOG_INPUT_ONE),
    .combine(PRIMARY_COMBINE),
    .direction(direction),
    .maximum(PRIMARY_REFERENCE_MAXIMUM),
    .scaled(primary_scaled)
);

reference_scaler #(
    .FULL_SCALE(10000)
) secondary_scaler (
    .clk(CLK),
    .rst(RST),
    .word(secondary_reference_word),
    .analog(ANALOG_INPUT_ONE),
    .combine(SECONDARY_COMBINE),
    .direction(direction),
    .maximum(SECONDARY_REFERENCE_MAXIMUM),
    .scaled(secondary_scaled)
);

////////////////////////////////////////////////////////////////////////////////
// Reference limits

// Magnitude clamp keeps the sign chosen by the direction logic; zero stays zero
function signed [15:0] magnitude_clamp;
    input signed [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    reg [16:0] m;
    begin
        m = v[15] ? (17'h0 - {v[15], v}) : {1'b0, v};
        if (m > {1'b0, hi})
            m = {1'b0, hi};
        else if (m != 17'h0 && m < {1'b0, lo})
            m = {1'b0, lo};
        magnitude_clamp = v[15] ? (16'h0000 - m[15:0]) : m[15:0];
    end
endfunction

wire signed [15:0] primary_limited;
wire signed [15:0] secondary_speed_limited;
wire signed [15:0] motor_low;
wire signed [15:0] motor_high;
wire signed [15:0] primary_drive;
reg signed [15:0] secondary_input;
reg signed [15:0] secondary_low;
reg signed [15:0] secondary_high;
wire signed [15:0] secondary_final;

assign primary_limited = magnitude_clamp(primary_scaled, PRIMARY_REFERENCE_MINIMUM,
                                         PRIMARY_REFERENCE_MAXIMUM);
assign secondary_speed_limited = magnitude_clamp(secondary_scaled,
                                                 SECONDARY_REFERENCE_MINIMUM,
                                                 SECONDARY_REFERENCE_MAXIMUM);
assign motor_low = FREQUENCY_MODE ? FREQUENCY_LIMIT_MIN : SPEED_LIMIT_MIN;
assign motor_high = FREQUENCY_MODE ? FREQUENCY_LIMIT_MAX : SPEED_LIMIT_MAX;

signed_limiter #(
    .WIDTH(16)
) motor_limiter (
    .value(primary_limited),
    .low(motor_low),
    .high(motor_high),
    .limited(primary_drive)
);

always @* begin
    case (SECONDARY_TYPE)
        `SEC_TYPE_TORQUE: begin
            secondary_input = secondary_scaled;
            secondary_low = TORQUE_SET_SELECT ? TORQUE2_LIMIT_MIN : TORQUE1_LIMIT_MIN;
            secondary_high = TORQUE_SET_SELECT ? TORQUE2_LIMIT_MAX : TORQUE1_LIMIT_MAX;
        end
        `SEC_TYPE_PID: begin
            secondary_input = secondary_scaled;
            secondary_low = PID_SET_SELECT ? PID2_SETPOINT_MIN : PID1_SETPOINT_MIN;
            secondary_high = PID_SET_SELECT ? PID2_SETPOINT_MAX : PID1_SETPOINT_MAX;
        end
        default: begin
            secondary_input = secondary_speed_limited;
            secondary_low = motor_low;
            secondary_high = motor_high;
        end
    endcase
end

signed_limiter #(
    .WIDTH(16)
) secondary_limiter (
    .value(secondary_input),
    .low(secondary_low),
    .high(secondary_high),
    .limited(secondary_final)
);

always @(posedge CLK or posedge RST) begin
    if (RST) begin
        PRIMARY_REFERENCE <= `WORD_RESET;
        PRIMARY_DRIVE_REFERENCE <= `WORD_RESET;
        SECONDARY_REFERENCE <= `WORD_RESET;
    end else begin
        PRIMARY_REFERENCE <= primary_limited;
        PRIMARY_DRIVE_REFERENCE <= primary_drive;
        SECONDARY_REFERENCE <= secondary_final;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Feedback scaling

reg signed [31:0] speed_scaled;
reg signed [31:0] torque_scaled;

always @* begin
    // A zero maximum would divide by zero, so report zero speed then
    if (PRIMARY_REFERENCE_MAXIMUM == 16'h0000)
        speed_scaled = 32'sh00000000;
    else
        // Extended word must stay signed, or the divide runs unsigned
        speed_scaled = $signed({{16{ACTUAL_SPEED[15]}}, ACTUAL_SPEED})
                       * $signed(`PRIMARY_FULL_SCALE)
                       / $signed({16'h0000, PRIMARY_REFERENCE_MAXIMUM});
    if (speed_scaled > $signed(`WORD_LIMIT))
        speed_scaled = `WORD_LIMIT;
    else if (speed_scaled < -$signed(`WORD_LIMIT))
        speed_scaled = -$signed(`WORD_LIMIT);
    torque_scaled = $signed({{16{ACTUAL_TORQUE[15]}}, ACTUAL_TORQUE})
                    * $signed(`TORQUE_INPUT_FACTOR);
    if (torque_scaled > $signed(`WORD_LIMIT))
        torque_scaled = `WORD_LIMIT;
    else if (torque_scaled < -$signed(`WORD_LIMIT))
        torque_scaled = -$signed(`WORD_LIMIT);
end

always @(posedge CLK or posedge RST) begin
    if (RST) begin
        speed_feedback_word <= `WORD_RESET;
        torque_feedback_word <= `WORD_RESET;
    end else begin
        speed_feedback_word <= speed_scaled[15:0];
        torque_feedback_word <= torque_scaled[15:0];
    end
end

endmodule // fieldbus_reference_scaling

`default_nettype wire

//--- tb/fbref_master.sv
`timescale 1ns/1ps
`default_nettype none
module fbref_master (
    input wire logic CLK,
    input wire logic [15:0] RDATA,
    output logic [2:0] ADDR,
    output logic WR,
    output logic RD,
    output logic [15:0] WDATA
);
    initial begin
        ADDR = 3'h0;
        WR = 1'b0;
        RD = 1'b0;
        WDATA = 16'h0000;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(negedge CLK);
        ADDR = a;
        WDATA = d;
        WR = 1'b1;
        @(negedge CLK);
        WR = 1'b0;
        // Released data must not look like valid data
        WDATA = ~d;
    endtask
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(negedge CLK);
        ADDR = a;
        RD = 1'b1;
        @(negedge CLK);
        RD = 1'b0;
        d = RDATA;
    endtask
endmodule // fbref_master
`default_nettype wire

//--- tb/fieldbus_reference_scaling_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module fieldbus_reference_scaling_monitor (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [2:0] ADDR,
    input wire logic WR,
    input wire logic RD,
    input wire logic [15:0] WDATA,
    input wire logic [15:0] RDATA,
    input wire logic [15:0] COMMAND_WORD,
    input wire logic EXTERNAL_LOCATION_SELECT,
    input wire logic FREQUENCY_MODE,
    input wire logic [1:0] SECONDARY_TYPE,
    input wire logic TORQUE_SET_SELECT,
    input wire logic PID_SET_SELECT,
    input wire logic [15:0] PRIMARY_REFERENCE_MAXIMUM,
    input wire logic signed [15:0] SPEED_LIMIT_MIN,
    input wire logic signed [15:0] SPEED_LIMIT_MAX,
    input wire logic signed [15:0] TORQUE1_LIMIT_MIN,
    input wire logic signed [15:0] TORQUE1_LIMIT_MAX,
    input wire logic signed [15:0] PID2_SETPOINT_MIN,
    input wire logic signed [15:0] PID2_SETPOINT_MAX,
    input wire logic signed [15:0] ACTUAL_TORQUE,
    input wire logic signed [15:0] PRIMARY_REFERENCE,
    input wire logic signed [15:0] PRIMARY_DRIVE_REFERENCE,
    input wire logic signed [15:0] SECONDARY_REFERENCE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    sequence torque_one_held;
        !RST && SECONDARY_TYPE == 2'h1 && !TORQUE_SET_SELECT
            && $stable(TORQUE1_LIMIT_MIN) && $stable(TORQUE1_LIMIT_MAX);
    endsequence
    sequence pid_two_held;
        !RST && SECONDARY_TYPE == 2'h2 && PID_SET_SELECT
            && $stable(PID2_SETPOINT_MIN) && $stable(PID2_SETPOINT_MAX);
    endsequence
    sequence speed_held;
        !RST && !FREQUENCY_MODE && $stable(SPEED_LIMIT_MIN) && $stable(SPEED_LIMIT_MAX);
    endsequence
    a_torque_pair_limit: assert property (torque_one_held ##1 torque_one_held |->
        SECONDARY_REFERENCE >= TORQUE1_LIMIT_MIN && SECONDARY_REFERENCE <= TORQUE1_LIMIT_MAX)
        else $error("torque reference outside set one limits");
    a_pid_pair_limit: assert property (pid_two_held [*2] |->
        SECONDARY_REFERENCE >= PID2_SETPOINT_MIN && SECONDARY_REFERENCE <= PID2_SETPOINT_MAX)
        else $error("setpoint outside set two limits");
    a_speed_pair_limit: assert property (speed_held ##1 speed_held |->
        PRIMARY_DRIVE_REFERENCE >= SPEED_LIMIT_MIN && PRIMARY_DRIVE_REFERENCE <= SPEED_LIMIT_MAX)
        else $error("drive reference outside speed limits");
    a_primary_max_sat: assert property ($stable(PRIMARY_REFERENCE_MAXIMUM) [*3] |->
        int'(PRIMARY_REFERENCE) <= int'(PRIMARY_REFERENCE_MAXIMUM)
        && -int'(PRIMARY_REFERENCE) <= int'(PRIMARY_REFERENCE_MAXIMUM))
        else $error("primary reference beyond maximum");
    a_torque_fb_scale: assert property (RD && ADDR == 3'h6 && !$past(RST)
        && $stable(ACTUAL_TORQUE) && ACTUAL_TORQUE <= 3276 && ACTUAL_TORQUE >= -3276
        |=> int'($signed(RDATA)) == int'($past(ACTUAL_TORQUE)) * 10)
        else $error("torque feedback word scaled wrongly");
    a_state_loc_flag: assert property (RD && ADDR == 3'h4 && !$past(RST)
        && $stable(EXTERNAL_LOCATION_SELECT) |=> RDATA[11] == $past(EXTERNAL_LOCATION_SELECT))
        else $error("location flag wrong in state word");
    a_unmapped_read_zero: assert property (RD && (ADDR == 3'h0 || ADDR == 3'h7)
        |=> RDATA == 16'h0000) else $error("unmapped read not zero");
    a_command_write: assert property (WR && ADDR == 3'h1 |=> COMMAND_WORD == $past(WDATA))
        else $error("command word not stored");
    a_command_hold: assert property (!(WR && ADDR == 3'h1) |=> $stable(COMMAND_WORD))
        else $error("command word changed without write");
endmodule // fieldbus_reference_scaling_monitor
bind fieldbus_reference_scaling fieldbus_reference_scaling_monitor mon (.*);
`default_nettype wire

//--- tb/fieldbus_reference_scaling_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fieldbus_reference_scaling_bench;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    wire [2:0] ADDR;
    wire WR, RD;
    wire [15:0] WDATA, RDATA, COMMAND_WORD;
    wire signed [15:0] PRIMARY_REFERENCE, PRIMARY_DRIVE_REFERENCE, SECONDARY_REFERENCE;
    logic [15:0] STATE_BITS, PRIMARY_REFERENCE_MAXIMUM, PRIMARY_REFERENCE_MINIMUM;
    logic [15:0] SECONDARY_REFERENCE_MAXIMUM, SECONDARY_REFERENCE_MINIMUM;
    logic EXTERNAL_LOCATION_SELECT, FREQUENCY_MODE, TORQUE_SET_SELECT, PID_SET_SELECT;
    logic [1:0] DIRECTION_ONE, DIRECTION_TWO, PRIMARY_COMBINE, SECONDARY_COMBINE, SECONDARY_TYPE;
    logic [9:0] ANALOG_INPUT_ONE;
    logic signed [15:0] SPEED_LIMIT_MIN, SPEED_LIMIT_MAX, FREQUENCY_LIMIT_MIN, FREQUENCY_LIMIT_MAX;
    logic signed [15:0] TORQUE1_LIMIT_MIN, TORQUE1_LIMIT_MAX, TORQUE2_LIMIT_MIN, TORQUE2_LIMIT_MAX;
    logic signed [15:0] PID1_SETPOINT_MIN, PID1_SETPOINT_MAX, PID2_SETPOINT_MIN, PID2_SETPOINT_MAX;
    logic signed [15:0] ACTUAL_SPEED, ACTUAL_TORQUE, w1, w2;
    logic [15:0] cmd, rv;
    logic [15:0] expect_word [8];
    int mismatches = 0;
    int n_tests = 0;
    int dir, p, s, lo, hi;
    int corner [4] = '{32767, -32767, 0, -20000};
    fieldbus_reference_scaling dut (.*);
    fbref_master m (.*);
    initial forever #12.5 CLK = ~CLK;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic int lim(int v, int l, int h);
        return v < l ? l : (v > h ? h : v);
    endfunction
    function automatic int mag(int v, int mn, int mx);
        int a = lim(v < 0 ? -v : v, mn, mx);
        return v == 0 ? 0 : (v < 0 ? -a : a);
    endfunction
    function automatic int scale(int w, int comb, int mx, int fs);
        int c = w;
        int a = int'(ANALOG_INPUT_ONE) * fs / 1000;
        if (comb == 1) c = w + a - fs / 2;
        if (comb == 2) c = w * a / (fs / 2);
        if (dir == 1) c = c < 0 ? -c : c;
        if (dir == 2) c = c < 0 ? c : -c;
        return lim(c, -fs, fs) * mx / fs;
    endfunction
    task automatic check(string name, logic [15:0] seen, logic [15:0] want);
        n_tests++;
        if (seen !== want) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, want, seen);
        end
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic shuffle(input int i);
        cmd = 16'($urandom);
        // First trials hit full scale, zero and negative extremes
        // Random words stay inside the accepted -32767..+32767 span
        w1 = i < 4 ? 16'(corner[i]) : 16'($urandom_range(65534)) - 16'h7FFF;
        w2 = i < 4 ? 16'(corner[3 - i]) : 16'($urandom_range(65534)) - 16'h7FFF;
        STATE_BITS = 16'($urandom);
        {EXTERNAL_LOCATION_SELECT, FREQUENCY_MODE, TORQUE_SET_SELECT, PID_SET_SELECT} = 4'($urandom);
        {DIRECTION_ONE, DIRECTION_TWO, PRIMARY_COMBINE, SECONDARY_COMBINE} = 8'($urandom);
        SECONDARY_TYPE = 2'($urandom);
        ANALOG_INPUT_ONE = 10'($urandom_range(1000));
        PRIMARY_REFERENCE_MAXIMUM = 16'($urandom_range(32767, 1));
        PRIMARY_REFERENCE_MINIMUM = 16'($urandom_range(int'(PRIMARY_REFERENCE_MAXIMUM) / 4));
        SECONDARY_REFERENCE_MAXIMUM = 16'($urandom_range(32767, 1));
        SECONDARY_REFERENCE_MINIMUM = 16'($urandom_range(int'(SECONDARY_REFERENCE_MAXIMUM) / 4));
        // Two draws per triple so the top field is random too
        {SPEED_LIMIT_MIN, FREQUENCY_LIMIT_MIN, TORQUE1_LIMIT_MIN} =
            48'({$urandom, $urandom}) | 48'h800080008000;
        {TORQUE2_LIMIT_MIN, PID1_SETPOINT_MIN, PID2_SETPOINT_MIN} =
            48'({$urandom, $urandom}) | 48'h800080008000;
        {SPEED_LIMIT_MAX, FREQUENCY_LIMIT_MAX, TORQUE1_LIMIT_MAX} =
            48'({$urandom, $urandom}) & 48'h7FFF7FFF7FFF;
        {TORQUE2_LIMIT_MAX, PID1_SETPOINT_MAX, PID2_SETPOINT_MAX} =
            48'({$urandom, $urandom}) & 48'h7FFF7FFF7FFF;
        ACTUAL_SPEED = 16'($urandom);
        ACTUAL_TORQUE = i[0] ? 16'($urandom) : 16'($urandom_range(6552)) - 16'h0CCC;
    endtask
    initial begin
        void'($urandom(2167));
        shuffle(9);
        repeat (16) @(negedge CLK);
        RST = 1'b0;
        for (int i = 0; i < 60; i++) begin
            @(negedge CLK);
            shuffle(i);
            m.wr(3'h1, cmd);
            m.wr(3'h2, w1);
            m.wr(3'h3, w2);
            for (int a = 4; a < 7; a++) m.wr(3'(a), ~cmd);
            repeat (3) @(negedge CLK);
            dir = EXTERNAL_LOCATION_SELECT ? DIRECTION_TWO : DIRECTION_ONE;
            lo = FREQUENCY_MODE ? FREQUENCY_LIMIT_MIN : SPEED_LIMIT_MIN;
            hi = FREQUENCY_MODE ? FREQUENCY_LIMIT_MAX : SPEED_LIMIT_MAX;
            p = mag(scale(w1, PRIMARY_COMBINE, PRIMARY_REFERENCE_MAXIMUM, 20000),
                PRIMARY_REFERENCE_MINIMUM, PRIMARY_REFERENCE_MAXIMUM);
            s = scale(w2, SECONDARY_COMBINE, SECONDARY_REFERENCE_MAXIMUM, 10000);
            case (SECONDARY_TYPE)
                2'h1: s = TORQUE_SET_SELECT ? lim(s, TORQUE2_LIMIT_MIN, TORQUE2_LIMIT_MAX)
                    : lim(s, TORQUE1_LIMIT_MIN, TORQUE1_LIMIT_MAX);
                2'h2: s = PID_SET_SELECT ? lim(s, PID2_SETPOINT_MIN, PID2_SETPOINT_MAX)
                    : lim(s, PID1_SETPOINT_MIN, PID1_SETPOINT_MAX);
                default: s = lim(mag(s, SECONDARY_REFERENCE_MINIMUM, SECONDARY_REFERENCE_MAXIMUM), lo, hi);
            endcase
            check("primary", PRIMARY_REFERENCE, 16'(p));
            check("drive", PRIMARY_DRIVE_REFERENCE, 16'(lim(p, lo, hi)));
            check("secondary", SECONDARY_REFERENCE, 16'(s));
            check("command", COMMAND_WORD, cmd);
            expect_word = '{16'h0000, cmd, w1, w2, STATE_BITS, 16'h0000, 16'h0000, 16'h0000};
            expect_word[4][11] = EXTERNAL_LOCATION_SELECT;
            expect_word[5] = 16'(lim(ACTUAL_SPEED * 20000 / int'(PRIMARY_REFERENCE_MAXIMUM),
                -32767, 32767));
            expect_word[6] = 16'(lim(ACTUAL_TORQUE * 10, -32767, 32767));
            for (int a = 0; a < 8; a++) begin
                m.rd(3'(a), rv);
                check("map word", rv, expect_word[a]);
            end
        end
        stop_test();
    end
    initial begin
        #150000;
        mismatches++;
        stop_test();
    end
endmodule // fieldbus_reference_scaling_bench
`default_nettype wire
